//--- rtl/ccrb_reg_bank.sv
// Top of the converter control register bank: a two-wire serial target
// holding identity, fault status and three configuration registers.
// Assumes open-drain data resolved outside and faults given as levels.
`timescale 1ns/1ns
module ccrb_reg_bank #(
	// Identity codes; values are arbitrary.
	parameter logic [3:0] VARIANT_CODE = 4'h9,
	parameter logic [2:0] REVISION_CODE = 3'h5
) (
	// Clock, reset, enable
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	// Serial bus pins
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_out,
	output logic o_sda_oe,
	// Supply, enable and strap pins
	input wire logic i_input_supply_ok,
	input wire logic i_enable_pin,
	input wire logic i_mode_pin,
	input wire logic i_ocp_option_pin,
	// Fault indications
	input wire logic i_thermal_trip,
	input wire logic i_power_good,
	input wire logic i_overvoltage,
	input wire logic i_overcurrent,
	// Operating configuration fields
	output logic o_ultrasonic_enable,
	output logic o_rise_ramp_select,
	output logic o_fall_slew_select,
	output logic [1:0] o_overvoltage_threshold,
	output logic o_active_discharge_enable,
	output logic o_forced_pwm_select,
	// Output and protection fields
	output logic o_converter_output_enable,
	output logic o_enable_pin_pulldown,
	output logic o_power_good_polarity,
	output logic o_peak_current_limit_select,
	// Output voltage code
	output logic [6:0] o_output_voltage_code
);

	// ----------------------------------------------------------------
	// Pin front end
	// ----------------------------------------------------------------
	ccrb_pins_if pins ();

	logic [ccrb_pkg::MISC_W-1:0] misc_raw;

	always_comb begin
		misc_raw = '0;
		misc_raw[ccrb_pkg::LV_SUPPLY] = i_input_supply_ok;
		misc_raw[ccrb_pkg::LV_ENABLE] = i_enable_pin;
		misc_raw[ccrb_pkg::LV_MODE] = i_mode_pin;
		misc_raw[ccrb_pkg::LV_OCP_OPT] = i_ocp_option_pin;
		misc_raw[ccrb_pkg::LV_THERMAL] = i_thermal_trip;
		misc_raw[ccrb_pkg::LV_PGOOD] = i_power_good;
		misc_raw[ccrb_pkg::LV_OVP] = i_overvoltage;
		misc_raw[ccrb_pkg::LV_OCP] = i_overcurrent;
	end

	ccrb_pin_sync u_sync (
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_ce(i_ce),
		.i_scl(i_scl),
		.i_sda(i_sda),
		.i_misc(misc_raw),
		.pins(pins)
	);

	// ----------------------------------------------------------------
	// Register storage
	// ----------------------------------------------------------------
	logic [7:0] opcfg_r;
	logic [7:0] opcfg_nxt;
	logic [7:0] outcfg_r;
	logic [7:0] outcfg_nxt;
	logic [7:0] output_voltage_code_r;
	logic [7:0] output_voltage_code_nxt;
	logic [7:0] status_r;
	logic [7:0] status_nxt;
	logic bank_rst;
	logic bank_hold_r;
	logic bank_hold_nxt;
	logic wr_en;
	logic [7:0] wr_ofs;
	logic [7:0] wr_data;

	// The bank stays in reset while supply or enable is low, and one cycle
	// longer: the straps arrive through the same synchroniser as the supply
	// level, so the extra cycle lets a strap default land after a hard reset.
	assign bank_rst = bank_hold_nxt | bank_hold_r; // see RULE_01

	always_comb begin
		opcfg_nxt = opcfg_r;
		outcfg_nxt = outcfg_r;
		output_voltage_code_nxt = output_voltage_code_r;
		status_nxt = 8'h00;
		bank_hold_nxt = ~pins.lvl[ccrb_pkg::LV_SUPPLY] | ~pins.lvl[ccrb_pkg::LV_ENABLE]; // see RULE_01
		// Reserved status bits stay zero.
		status_nxt[3] = pins.lvl[ccrb_pkg::LV_THERMAL]; // see RULE_04
		status_nxt[2] = pins.lvl[ccrb_pkg::LV_PGOOD]; // see RULE_05
		status_nxt[1] = pins.lvl[ccrb_pkg::LV_OVP]; // see RULE_05
		status_nxt[0] = pins.lvl[ccrb_pkg::LV_OCP]; // see RULE_05
		if (bank_rst) begin
			opcfg_nxt = ccrb_pkg::OPCFG_RST; // see RULE_07, RULE_08, RULE_09
			opcfg_nxt[ccrb_pkg::OPCFG_PWM_BIT] = pins.lvl[ccrb_pkg::LV_MODE]; // see RULE_10
			outcfg_nxt = ccrb_pkg::OUTCFG_RST;
			outcfg_nxt[ccrb_pkg::OUTCFG_OCP_BIT] = pins.lvl[ccrb_pkg::LV_OCP_OPT]; // see RULE_15
			output_voltage_code_nxt = ccrb_pkg::OUTPUT_VOLTAGE_CODE_RST; // see RULE_14
		end else if (wr_en) begin
			unique case (wr_ofs)
				ccrb_pkg::OFS_OPCFG: begin
					opcfg_nxt = wr_data & ccrb_pkg::OPCFG_MASK; // see RULE_11, RULE_16
				end
				ccrb_pkg::OFS_OUTCFG: begin
					outcfg_nxt = wr_data & ccrb_pkg::OUTCFG_MASK; // see RULE_16
				end
				ccrb_pkg::OFS_OUTPUT_VOLTAGE_CODE: begin
					output_voltage_code_nxt = wr_data & ccrb_pkg::OUTPUT_VOLTAGE_CODE_MASK; // see RULE_16
				end
				// Identity, status and unmapped offsets drop the byte.
				default: begin
					opcfg_nxt = opcfg_r; // see RULE_16
				end
			endcase
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			opcfg_r <= ccrb_pkg::OPCFG_RST;
			outcfg_r <= ccrb_pkg::OUTCFG_RST;
			output_voltage_code_r <= ccrb_pkg::OUTPUT_VOLTAGE_CODE_RST;
			status_r <= 8'h00;
			bank_hold_r <= 1'b1;
		end else if (i_ce) begin
			bank_hold_r <= bank_hold_nxt;
			opcfg_r <= opcfg_nxt;
			outcfg_r <= outcfg_nxt;
			output_voltage_code_r <= output_voltage_code_nxt;
			status_r <= status_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Read multiplexer
	// ----------------------------------------------------------------
	logic [7:0] ptr_r;
	logic [7:0] rdata;

	always_comb begin
		unique case (ptr_r)
			ccrb_pkg::OFS_IDENTITY: rdata = {1'b0, VARIANT_CODE, REVISION_CODE}; // see RULE_03
			ccrb_pkg::OFS_STATUS: rdata = status_r;
			ccrb_pkg::OFS_OPCFG: rdata = opcfg_r;
			ccrb_pkg::OFS_OUTCFG: rdata = outcfg_r;
			ccrb_pkg::OFS_OUTPUT_VOLTAGE_CODE: rdata = output_voltage_code_r;
			default: rdata = ccrb_pkg::UNMAPPED_READ;
		endcase
	end

	// ----------------------------------------------------------------
	// Serial target engine
	// ----------------------------------------------------------------
	ccrb_pkg::ccrb_state_t state_r;
	ccrb_pkg::ccrb_state_t state_nxt;
	ccrb_pkg::ccrb_kind_t kind_r;
	ccrb_pkg::ccrb_kind_t kind_nxt;
	logic [7:0] shreg_r;
	logic [7:0] shreg_nxt;
	logic [3:0] bitcnt_r;
	logic [3:0] bitcnt_nxt;
	logic [7:0] ptr_nxt;
	logic rd_mode_r;
	logic rd_mode_nxt;
	logic sda_oe_r;
	logic sda_oe_nxt;

	always_comb begin
		state_nxt = state_r;
		kind_nxt = kind_r;
		shreg_nxt = shreg_r;
		bitcnt_nxt = bitcnt_r;
		ptr_nxt = ptr_r;
		rd_mode_nxt = rd_mode_r;
		sda_oe_nxt = sda_oe_r;
		wr_en = 1'b0;
		wr_ofs = ptr_r;
		wr_data = shreg_r;
		if (pins.stop_det) begin
			state_nxt = ccrb_pkg::ST_IDLE;
			sda_oe_nxt = 1'b0;
		end else if (pins.start_det) begin
			state_nxt = ccrb_pkg::ST_RECV;
			kind_nxt = ccrb_pkg::K_ADDR;
			bitcnt_nxt = 4'h0;
			sda_oe_nxt = 1'b0;
		end else begin
			unique case (state_r)
				ccrb_pkg::ST_IDLE: begin
					sda_oe_nxt = 1'b0;
				end
				ccrb_pkg::ST_RECV: begin
					if (pins.scl_rise && bitcnt_r != ccrb_pkg::BYTE_BITS) begin
						shreg_nxt = {shreg_r[6:0], pins.sda};
						bitcnt_nxt = bitcnt_r + 4'h1;
					end else if (pins.scl_fall && bitcnt_r == ccrb_pkg::BYTE_BITS) begin
						state_nxt = ccrb_pkg::ST_ACK;
						sda_oe_nxt = 1'b1;
						unique case (kind_r)
							ccrb_pkg::K_ADDR: begin
								if (shreg_r == ccrb_pkg::ADDR_WR_BYTE) begin // see RULE_02
									rd_mode_nxt = 1'b0;
								end else if (shreg_r == ccrb_pkg::ADDR_RD_BYTE) begin // see RULE_02
									rd_mode_nxt = 1'b1;
								end else begin
									state_nxt = ccrb_pkg::ST_IDLE;
									sda_oe_nxt = 1'b0;
								end
							end
							ccrb_pkg::K_PTR: begin
								ptr_nxt = shreg_r;
							end
							default: begin
								rd_mode_nxt = 1'b0;
							end
						endcase
					end
				end
				ccrb_pkg::ST_ACK: begin
					if (pins.scl_fall) begin
						bitcnt_nxt = 4'h0;
						sda_oe_nxt = 1'b0;
						state_nxt = ccrb_pkg::ST_RECV;
						if (kind_r == ccrb_pkg::K_DATA) begin
							wr_en = 1'b1; // see RULE_13
							ptr_nxt = ptr_r + 8'h01; // see RULE_12
						end else if (rd_mode_r) begin
							// Status is captured here and then shifted, so a
							// fault edge mid-byte cannot tear the value.
							shreg_nxt = rdata; // see RULE_17
							sda_oe_nxt = ~rdata[7];
							state_nxt = ccrb_pkg::ST_SEND;
						end else if (kind_r == ccrb_pkg::K_ADDR) begin
							kind_nxt = ccrb_pkg::K_PTR;
						end else begin
							kind_nxt = ccrb_pkg::K_DATA;
						end
					end
				end
				ccrb_pkg::ST_SEND: begin
					if (pins.scl_rise) begin
						bitcnt_nxt = bitcnt_r + 4'h1;
					end else if (pins.scl_fall) begin
						if (bitcnt_r == ccrb_pkg::BYTE_BITS) begin
							sda_oe_nxt = 1'b0;
							state_nxt = ccrb_pkg::ST_MACK;
						end else begin
							shreg_nxt = {shreg_r[6:0], 1'b0};
							sda_oe_nxt = ~shreg_r[6];
						end
					end
				end
				ccrb_pkg::ST_MACK: begin
					if (pins.scl_rise) begin
						if (pins.sda) begin
							state_nxt = ccrb_pkg::ST_IDLE;
						end else begin
							ptr_nxt = ptr_r + 8'h01; // see RULE_12
							state_nxt = ccrb_pkg::ST_RELOAD;
						end
					end
				end
				ccrb_pkg::ST_RELOAD: begin
					if (pins.scl_fall) begin
						shreg_nxt = rdata; // see RULE_17
						sda_oe_nxt = ~rdata[7];
						bitcnt_nxt = 4'h0;
						state_nxt = ccrb_pkg::ST_SEND;
					end
				end
				default: begin
					state_nxt = ccrb_pkg::ST_IDLE;
					sda_oe_nxt = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			state_r <= ccrb_pkg::ST_IDLE;
			kind_r <= ccrb_pkg::K_ADDR;
			shreg_r <= 8'h00;
			bitcnt_r <= 4'h0;
			ptr_r <= 8'h00;
			rd_mode_r <= 1'b0;
			sda_oe_r <= 1'b0;
		end else if (i_ce) begin
			state_r <= state_nxt;
			kind_r <= kind_nxt;
			shreg_r <= shreg_nxt;
			bitcnt_r <= bitcnt_nxt;
			ptr_r <= ptr_nxt;
			rd_mode_r <= rd_mode_nxt;
			sda_oe_r <= sda_oe_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Open drain: the line is only ever pulled low.
	assign o_sda_out = 1'b0;
	assign o_sda_oe = sda_oe_r;
	assign o_ultrasonic_enable = opcfg_r[ccrb_pkg::OPCFG_ULTRA_BIT]; // see RULE_06
	assign o_rise_ramp_select = opcfg_r[ccrb_pkg::OPCFG_RISE_BIT]; // see RULE_07
	assign o_fall_slew_select = opcfg_r[ccrb_pkg::OPCFG_FALL_BIT]; // see RULE_07
	assign o_overvoltage_threshold = opcfg_r[ccrb_pkg::OPCFG_OVTH_LSB +: 2]; // see RULE_08
	assign o_active_discharge_enable = opcfg_r[ccrb_pkg::OPCFG_DISCH_BIT]; // see RULE_09
	assign o_forced_pwm_select = opcfg_r[ccrb_pkg::OPCFG_PWM_BIT]; // see RULE_10
	assign o_converter_output_enable = outcfg_r[ccrb_pkg::OUTCFG_EN_BIT];
	assign o_enable_pin_pulldown = outcfg_r[ccrb_pkg::OUTCFG_PD_BIT];
	assign o_power_good_polarity = outcfg_r[ccrb_pkg::OUTCFG_POL_BIT];
	assign o_peak_current_limit_select = outcfg_r[ccrb_pkg::OUTCFG_OCP_BIT]; // see RULE_15
	assign o_output_voltage_code = output_voltage_code_r[6:0]; // see RULE_14

endmodule // ccrb_reg_bank

//--- rtl/ccrb_pkg.sv
// Package of the converter control register bank: offsets, field layout,
// reset values, target address bytes and the state encodings.
// Assumes a two-wire serial host outside and analogue fault indications in.
//
// What this block does
// RULE_01 - Supply or enable low resets every configuration register.
// RULE_02 - Answer target bytes 0x86 write, 0x87 read.
// RULE_03 - Identity read-only: zero, variant code, revision code.
// RULE_04 - Thermal bit one at or above 150 C.
// RULE_05 - Fault bits follow faults, clear by themselves.
// RULE_06 - Ultrasonic bit keeps switching above 20 kHz.
// RULE_07 - Ramp and slew select bits, both default zero.
// RULE_08 - Overvoltage field: off, 110, 115, 120 percent.
// RULE_09 - Active discharge bit enables discharge, resets one.
// RULE_10 - Operating config resets 0x0E or 0x0F by mode.
// RULE_11 - Ultrasonic control writable zero for normal operation.
// RULE_12 - Pointer advances by one after each written byte and each acked read byte.
// RULE_13 - Written byte commits on SCL fall after ack.
// RULE_14 - Voltage code 2.60 V plus 20 mV steps, default 0x28.
// RULE_15 - Peak current select 2.5 A or 4.4 A, strap default.
// RULE_16 - Reserved bits zero; read-only registers ignore writes.
// RULE_17 - Status read sampled once, stable over the byte.
package ccrb_pkg;

	// ----------------------------------------------------------------
	// Target address bytes
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_WR_BYTE = 8'h86;
	localparam logic [7:0] ADDR_RD_BYTE = 8'h87;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_IDENTITY = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h01;
	localparam logic [7:0] OFS_OPCFG = 8'h02;
	localparam logic [7:0] OFS_OUTCFG = 8'h03;
	localparam logic [7:0] OFS_OUTPUT_VOLTAGE_CODE = 8'h04;

	// ----------------------------------------------------------------
	// Reset values and writable masks
	// ----------------------------------------------------------------
	localparam logic [7:0] OPCFG_RST = 8'h0e;
	localparam logic [7:0] OPCFG_MASK = 8'h7f;
	localparam logic [7:0] OUTCFG_RST = 8'h70;
	localparam logic [7:0] OUTCFG_MASK = 8'h78;
	localparam logic [7:0] OUTPUT_VOLTAGE_CODE_RST = 8'h28;
	localparam logic [7:0] OUTPUT_VOLTAGE_CODE_MASK = 8'h7f;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int ID_VARIANT_LSB = 3;
	localparam int ID_VARIANT_W = 4;
	localparam int ID_REV_W = 3;
	localparam int OPCFG_ULTRA_BIT = 6;
	localparam int OPCFG_RISE_BIT = 5;
	localparam int OPCFG_FALL_BIT = 4;
	localparam int OPCFG_OVTH_LSB = 2;
	localparam int OPCFG_DISCH_BIT = 1;
	localparam int OPCFG_PWM_BIT = 0;
	localparam int OUTCFG_EN_BIT = 6;
	localparam int OUTCFG_PD_BIT = 5;
	localparam int OUTCFG_POL_BIT = 4;
	localparam int OUTCFG_OCP_BIT = 3;

	// ----------------------------------------------------------------
	// Analogue meaning of fields
	// ----------------------------------------------------------------
	localparam int THERMAL_LIMIT_C = 150;
	localparam int ULTRASONIC_MIN_KHZ = 20;
	localparam int OUTPUT_VOLTAGE_CODE_BASE_MV = 2600;
	localparam int OUTPUT_VOLTAGE_CODE_STEP_MV = 20;

	// ----------------------------------------------------------------
	// Synchronised level inputs
	// ----------------------------------------------------------------
	localparam int MISC_W = 8;
	localparam int LV_SUPPLY = 0;
	localparam int LV_ENABLE = 1;
	localparam int LV_MODE = 2;
	localparam int LV_OCP_OPT = 3;
	localparam int LV_THERMAL = 4;
	localparam int LV_PGOOD = 5;
	localparam int LV_OVP = 6;
	localparam int LV_OCP = 7;

	localparam logic [3:0] BYTE_BITS = 4'h8;

	// ----------------------------------------------------------------
	// Serial engine states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {ST_IDLE, ST_RECV, ST_ACK, ST_SEND, ST_MACK, ST_RELOAD} ccrb_state_t;
	typedef enum logic [1:0] {K_ADDR, K_PTR, K_DATA} ccrb_kind_t;

endpackage

//--- rtl/ccrb_pins_if.sv
// Interface carrying synchronised pin levels and bus events from the
// pin front end to the register bank.
// Assumes both ends run on the same reference clock.
`timescale 1ns/1ns
interface ccrb_pins_if;
	logic scl;
	logic sda;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic [ccrb_pkg::MISC_W-1:0] lvl;

	modport src (output scl, output sda, output scl_rise, output scl_fall, output start_det, output stop_det,
		output lvl);
	modport snk (input scl, input sda, input scl_rise, input scl_fall, input start_det, input stop_det,
		input lvl);
endinterface

//--- rtl/ccrb_pin_sync.sv
// Pin front end: two-flop synchronisers for every outside level, then
// edge, START and STOP detection from the second stage and its one-cycle delayed copy.
// Assumes the serial clock is at least eight reference clocks long.
`timescale 1ns/1ns
module ccrb_pin_sync (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	// Raw pins
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic [ccrb_pkg::MISC_W-1:0] i_misc,
	// Synchronised side
	ccrb_pins_if.src pins
);

	localparam int W = ccrb_pkg::MISC_W + 2;

	logic [W-1:0] s1_r;
	logic [W-1:0] s1_nxt;
	logic [W-1:0] s2_r;
	logic [W-1:0] s2_nxt;
	logic [1:0] prev_r;
	logic [1:0] prev_nxt;

	always_comb begin
		s1_nxt = {i_misc, i_sda, i_scl};
		s2_nxt = s1_r;
		prev_nxt = s2_r[1:0];
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			s1_r <= W'(2'h3);
			s2_r <= W'(2'h3);
			prev_r <= 2'h3;
		end else if (i_ce) begin
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
			prev_r <= prev_nxt;
		end
	end

	// Bit 0 is the clock line, bit 1 the data line.
	assign pins.scl = s2_r[0];
	assign pins.sda = s2_r[1];
	assign pins.lvl = s2_r[W-1:2];
	assign pins.scl_rise = i_ce & s2_r[0] & ~prev_r[0];
	assign pins.scl_fall = i_ce & ~s2_r[0] & prev_r[0];
	assign pins.start_det = i_ce & s2_r[0] & prev_r[0] & prev_r[1] & ~s2_r[1];
	assign pins.stop_det = i_ce & s2_r[0] & prev_r[0] & ~prev_r[1] & s2_r[1];

endmodule // ccrb_pin_sync

//--- test/ccrb_reg_bank_asserts.sv
// Concurrent checks on the register bank top ports.
// Assumes binding to ccrb_reg_bank with the bench driving every input.
`timescale 1ns/1ns
module ccrb_reg_bank_checker (
	// Clock and pins
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_scl,
	input wire logic i_input_supply_ok,
	input wire logic i_enable_pin,
	input wire logic i_mode_pin,
	input wire logic i_ocp_option_pin,
	// Watched outputs
	input wire logic o_sda_out,
	input wire logic o_sda_oe,
	input wire logic o_ultrasonic_enable,
	input wire logic o_rise_ramp_select,
	input wire logic o_fall_slew_select,
	input wire logic [1:0] o_overvoltage_threshold,
	input wire logic o_active_discharge_enable,
	input wire logic o_forced_pwm_select,
	input wire logic o_converter_output_enable,
	input wire logic o_enable_pin_pulldown,
	input wire logic o_power_good_polarity,
	input wire logic o_peak_current_limit_select,
	input wire logic [6:0] o_output_voltage_code
);
	// ----
	// Helper counters
	// ----
	// Cycles since the last SCL fall and since supply and enable both went high, both saturating.
	logic scl_d_r, scl_d_nxt;
	logic [3:0] fall_cnt_r, fall_cnt_nxt, en_cnt_r, en_cnt_nxt;
	logic [17:0] cfg;
	assign cfg = {o_ultrasonic_enable, o_rise_ramp_select, o_fall_slew_select, o_overvoltage_threshold,
		o_active_discharge_enable, o_forced_pwm_select, o_converter_output_enable, o_enable_pin_pulldown,
		o_power_good_polarity, o_peak_current_limit_select, o_output_voltage_code};
	always_comb begin
		scl_d_nxt = i_scl;
		fall_cnt_nxt = (scl_d_r && !i_scl) ? 4'h0 : ((fall_cnt_r == 4'hf) ? fall_cnt_r : fall_cnt_r + 4'h1);
		en_cnt_nxt = (i_input_supply_ok && i_enable_pin) ? ((en_cnt_r == 4'hf) ? en_cnt_r : en_cnt_r + 4'h1) : 4'h0;
		if (i_rst) begin
			scl_d_nxt = 1'b1;
			fall_cnt_nxt = 4'hf;
			en_cnt_nxt = 4'h0;
		end
	end
	always_ff @(posedge i_ref_clk) begin
		scl_d_r <= scl_d_nxt;
		fall_cnt_r <= fall_cnt_nxt;
		en_cnt_r <= en_cnt_nxt;
	end
	// ----
	// Properties
	// ----
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	a_enable_defaults: assert property (
		(!i_enable_pin) [*5] |-> cfg[17:12] == 6'h07 && cfg[10:8] == 3'h7 && o_output_voltage_code == 7'h28)
		else $error("config not at defaults while enable low");
	a_supply_defaults: assert property (
		(!i_input_supply_ok) [*5] |-> o_output_voltage_code == 7'h28 && o_overvoltage_threshold == 2'h3)
		else $error("config not at defaults while supply low");
	a_mode_strap_default: assert property (
		(!i_input_supply_ok && $stable(i_mode_pin)) [*5] |-> o_forced_pwm_select == i_mode_pin)
		else $error("pwm select does not follow mode strap");
	a_ocp_strap_default: assert property (
		(!i_enable_pin && $stable(i_ocp_option_pin)) [*5] |-> o_peak_current_limit_select == i_ocp_option_pin)
		else $error("current limit select does not follow strap");
	a_commit_on_fall: assert property (
		$changed(cfg) && en_cnt_r == 4'hf |-> !i_scl && fall_cnt_r inside {[4'h1:4'h7]})
		else $error("config changed away from an SCL fall");
	a_ack_after_fall: assert property (
		$rose(o_sda_oe) |-> !i_scl && fall_cnt_r inside {[4'h1:4'h5]})
		else $error("data line pulled low away from an SCL fall");
	a_bit_held_high: assert property (
		$rose(i_scl) |=> $stable(o_sda_oe) [*4])
		else $error("data line moved while SCL high");
	a_open_drain_low: assert property (
		o_sda_out == 1'b0)
		else $error("data output value not low");
endmodule // ccrb_reg_bank_checker

bind ccrb_reg_bank ccrb_reg_bank_checker u_chk (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_scl(i_scl),
	.i_input_supply_ok(i_input_supply_ok), .i_enable_pin(i_enable_pin), .i_mode_pin(i_mode_pin),
	.i_ocp_option_pin(i_ocp_option_pin), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
	.o_ultrasonic_enable(o_ultrasonic_enable), .o_rise_ramp_select(o_rise_ramp_select),
	.o_fall_slew_select(o_fall_slew_select), .o_overvoltage_threshold(o_overvoltage_threshold),
	.o_active_discharge_enable(o_active_discharge_enable), .o_forced_pwm_select(o_forced_pwm_select),
	.o_converter_output_enable(o_converter_output_enable), .o_enable_pin_pulldown(o_enable_pin_pulldown),
	.o_power_good_polarity(o_power_good_polarity), .o_peak_current_limit_select(o_peak_current_limit_select),
	.o_output_voltage_code(o_output_voltage_code));

//--- test/ccrb_host_model.sv
// Two-wire bus host model: drives SCL, pulls SDA low, reads the wire.
// Assumes a pull-up on SDA and the bank as the only target.
`timescale 1ns/1ns
module ccrb_host_model (
	// Clock and wire
	input wire logic i_ref_clk,
	input wire logic i_sda,
	// Driven lines
	output logic o_scl,
	output logic o_sda_low
);
	// ----
	// Bus cycles
	// ----
	// Idle is SCL high with SDA left to the pull-up; the clock stands still between frames.
	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge i_ref_clk);
		#1;
	endtask
	// The long low phase gives the target time to release its acknowledge before a repeated start.
	task automatic bus_start();
		o_sda_low = 1'b0;
		tick(4);
		o_scl = 1'b1;
		tick(4);
		o_sda_low = 1'b1;
		tick(4);
		o_scl = 1'b0;
	endtask
	task automatic bus_stop();
		tick(4);
		o_sda_low = 1'b1;
		tick(2);
		o_scl = 1'b1;
		tick(4);
		o_sda_low = 1'b0;
		tick(4);
	endtask
	task automatic bit_xfer(input logic b, output logic s);
		tick(2);
		o_sda_low = ~b;
		tick(2);
		o_scl = 1'b1;
		tick(2);
		s = i_sda;
		tick(2);
		o_scl = 1'b0;
	endtask
	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_xfer(b[i], s);
		bit_xfer(1'b1, s);
		ack = ~s;
	endtask
	task automatic recv_byte(input logic last, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_xfer(1'b1, s);
			b[i] = s;
		end
		bit_xfer(last, s);
	endtask
endmodule // ccrb_host_model

//--- test/tb.sv
// Self-checking bench for the register bank over the two-wire bus.
// Assumes the host model owns SCL and shares SDA with the bank.
`timescale 1ns/1ns
module tb;
	// Identity codes handed to the bank; values are arbitrary.
	localparam logic [3:0] VAR = 4'h6;
	localparam logic [2:0] REV = 3'h3;
	logic i_ref_clk = 1'b0;
	logic i_rst = 1'b1;
	logic supply = 1'b1, en = 1'b1, mode = 1'b0, ocp_opt = 1'b0;
	logic [3:0] faults = 4'h5;
	logic scl, host_low, sda, oe, sda_out, ack, u, rr, fs, ad, pwm, cen, pd, pol, peak_current_limit_select;
	logic [1:0] ovt;
	logic [6:0] code;
	logic [7:0] opcfg_pins, outcfg_pins, output_voltage_code_pins, d;
	logic [7:0] rbuf [0:4];
	logic [7:0] bad [0:2] = '{8'h00, 8'h84, 8'h96};
	int err_total = 0;
	int cmp_count = 0;
	assign sda = !(host_low || (oe && !sda_out));
	assign opcfg_pins = {1'b0, u, rr, fs, ovt, ad, pwm};
	assign outcfg_pins = {1'b0, cen, pd, pol, peak_current_limit_select, 3'h0};
	assign output_voltage_code_pins = {1'b0, code};
	always #5 i_ref_clk = ~i_ref_clk;
	ccrb_reg_bank #(.VARIANT_CODE(VAR), .REVISION_CODE(REV)) DUT (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
		.i_ce(1'b1), .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(oe), .i_input_supply_ok(supply),
		.i_enable_pin(en), .i_mode_pin(mode), .i_ocp_option_pin(ocp_opt), .i_thermal_trip(faults[3]),
		.i_power_good(faults[2]), .i_overvoltage(faults[1]), .i_overcurrent(faults[0]), .o_ultrasonic_enable(u),
		.o_rise_ramp_select(rr), .o_fall_slew_select(fs), .o_overvoltage_threshold(ovt),
		.o_active_discharge_enable(ad), .o_forced_pwm_select(pwm), .o_converter_output_enable(cen),
		.o_enable_pin_pulldown(pd), .o_power_good_polarity(pol), .o_peak_current_limit_select(peak_current_limit_select),
		.o_output_voltage_code(code));
	ccrb_host_model host (.i_ref_clk(i_ref_clk), .i_sda(sda), .o_scl(scl), .o_sda_low(host_low));
	// ----
	// Tasks
	// ----
	task automatic print_verdict();
		if (err_total == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_ref_clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] ptr, input logic [7:0] d0, input logic [7:0] d1, input int n);
		logic a, all;
		host.bus_start();
		host.send_byte(ccrb_pkg::ADDR_WR_BYTE, all);
		host.send_byte(ptr, a);
		all &= a;
		host.send_byte(d0, a);
		all &= a;
		if (n > 1) begin
			host.send_byte(d1, a);
			all &= a;
		end
		host.bus_stop();
		chk_bit(all, 1'b1);
	endtask
	task automatic rd(input logic [7:0] ptr, input int n);
		logic a, all;
		host.bus_start();
		host.send_byte(ccrb_pkg::ADDR_WR_BYTE, all);
		host.send_byte(ptr, a);
		all &= a;
		host.bus_start();
		host.send_byte(ccrb_pkg::ADDR_RD_BYTE, a);
		all &= a;
		for (int i = 0; i < n; i++) host.recv_byte(i == n - 1, rbuf[i]);
		host.bus_stop();
		chk_bit(all, 1'b1);
	endtask
	// ----
	// Tests
	// ----
	initial begin
		tick(12);
		i_rst = 1'b0;
		tick(8);
		rd(8'h00, 5);
		chk_byte(rbuf[0], {1'b0, VAR, REV});
		chk_byte(rbuf[1], 8'h05);
		chk_byte(rbuf[2], 8'h0e);
		chk_byte(rbuf[3], 8'h70);
		chk_byte(rbuf[4], 8'h28);
		chk_byte(opcfg_pins, 8'h0e);
		wr(8'h02, 8'hff, 8'hff, 2);
		chk_byte(opcfg_pins, 8'h7f);
		chk_byte(outcfg_pins, 8'h78);
		for (int k = 0; k < 4; k++) begin
			d = {1'b0, k[0], k[0], k[1], k[1:0], k[1], k[0]};
			wr(8'h02, d, 8'h00, 1);
			chk_byte(opcfg_pins, d);
			rd(8'h02, 1);
			chk_byte(rbuf[0], d);
		end
		wr(8'h00, 8'hff, 8'hff, 2);
		wr(8'h03, 8'h00, 8'h80, 2);
		chk_byte(outcfg_pins, 8'h00);
		chk_byte(output_voltage_code_pins, 8'h00);
		rd(8'h00, 2);
		chk_byte(rbuf[0], {1'b0, VAR, REV});
		chk_byte(rbuf[1], 8'h05);
		wr(8'h04, 8'h7f, 8'h00, 1);
		rd(8'h04, 2);
		chk_byte(rbuf[0], 8'h7f);
		chk_byte(rbuf[1], 8'h00);
		for (int k = 0; k < 5; k++) begin
			faults = 4'h1 << k;
			tick(4);
			rd(8'h01, 1);
			chk_byte(rbuf[0], {4'h0, faults});
		end
		foreach (bad[i]) begin
			host.bus_start();
			host.send_byte(bad[i], ack);
			host.bus_stop();
			chk_bit(ack, 1'b0);
		end
		mode = 1'b1;
		ocp_opt = 1'b1;
		en = 1'b0;
		tick(8);
		chk_byte(opcfg_pins, 8'h0f);
		chk_byte(outcfg_pins, 8'h78);
		chk_byte(output_voltage_code_pins, 8'h28);
		en = 1'b1;
		tick(8);
		rd(8'h02, 3);
		chk_byte(rbuf[0], 8'h0f);
		chk_byte(rbuf[1], 8'h78);
		chk_byte(rbuf[2], 8'h28);
		wr(8'h04, 8'h11, 8'h00, 1);
		chk_byte(output_voltage_code_pins, 8'h11);
		supply = 1'b0;
		tick(8);
		supply = 1'b1;
		tick(8);
		rd(8'h04, 1);
		chk_byte(rbuf[0], 8'h28);
		i_rst = 1'b1;
		tick(2);
		i_rst = 1'b0;
		tick(8);
		chk_byte(opcfg_pins, 8'h0f);
		print_verdict();
	end
	// A full run takes well under 20k clocks; this cuts a hung bus short.
	initial begin
		#500000;
		err_total++;
		print_verdict();
	end
endmodule // tb
